/* hw/ctd_pkg.sv */
// Opcodes, field codes and cycle counts for the control-transfer decoder
package ctd_pkg;
	// =========================================================
	// Opcodes
	localparam logic [7:0] OP_JMP_SHORT = 8'heb;
	localparam logic [7:0] OP_JMP_NEAR = 8'he9;
	localparam logic [7:0] OP_JMP_FAR = 8'hea;
	localparam logic [7:0] OP_GROUP_FF = 8'hff;
	localparam logic [7:0] OP_RET_NEAR = 8'hc3;
	localparam logic [7:0] OP_RET_NEAR_IMM = 8'hc2;
	localparam logic [7:0] OP_RET_FAR = 8'hcb;
	localparam logic [7:0] OP_RET_FAR_IMM = 8'hca;
	localparam logic [3:0] OP_JCC_HIGH = 4'h7;
	localparam logic [7:0] OP_JUMP_IF_COUNT_ZERO = 8'he3;
	localparam logic [7:0] OP_LOOP = 8'he2;
	localparam logic [7:0] OP_LOOPZ = 8'he1;
	localparam logic [7:0] OP_LOOPNZ = 8'he0;
	localparam logic [7:0] OP_ENTER = 8'hc8;
	localparam logic [7:0] OP_LEAVE = 8'hc9;
	localparam logic [7:0] OP_INT = 8'hcd;
	localparam logic [7:0] OP_INT3 = 8'hcc;
	localparam logic [7:0] OP_INTERRUPT_ON_OVERFLOW = 8'hce;
	localparam logic [7:0] OP_INTERRUPT_RETURN = 8'hcf;
	localparam logic [7:0] OP_BOUND = 8'h62;
	localparam logic [7:0] OP_CLC = 8'hf8;
	localparam logic [7:0] OP_CMC = 8'hf5;
	localparam logic [7:0] OP_STC = 8'hf9;
	localparam logic [7:0] OP_CLD = 8'hfc;
	localparam logic [7:0] OP_STD = 8'hfd;
	localparam logic [7:0] OP_CLI = 8'hfa;
	localparam logic [7:0] OP_STI = 8'hfb;
	localparam logic [7:0] OP_HLT = 8'hf4;
	localparam logic [7:0] OP_WAIT = 8'h9b;
	localparam logic [7:0] OP_LOCK = 8'hf0;
	localparam logic [7:0] OP_NOP = 8'h90;
	// =========================================================
	// Mod-reg-r/m fields and the breakpoint vector
	localparam logic [2:0] REG_JMP_IND = 3'h4;
	localparam logic [2:0] REG_JMP_FAR_IND = 3'h5;
	localparam logic [1:0] MOD_REGISTER = 2'h3;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [2:0] RM_DIRECT = 3'h6;
	localparam logic [7:0] VEC_BREAK = 8'h03;
	// =========================================================
	// Cycle counts
	localparam logic [15:0] CYC_JMP = 16'h000e;
	localparam logic [15:0] CYC_JMP_IND_REG = 16'h000b;
	localparam logic [15:0] CYC_JMP_IND_MEM = 16'h0015;
	localparam logic [15:0] CYC_JMP_FAR_IND = 16'h0022;
	localparam logic [15:0] CYC_RET_NEAR = 16'h0014;
	localparam logic [15:0] CYC_RET_NEAR_IMM = 16'h0016;
	localparam logic [15:0] CYC_RET_FAR = 16'h001e;
	localparam logic [15:0] CYC_RET_FAR_IMM = 16'h0021;
	localparam logic [15:0] CYC_JCC_NT = 16'h0004;
	localparam logic [15:0] CYC_JCC_T = 16'h000d;
	localparam logic [15:0] CYC_JUMP_IF_COUNT_ZERO_NT = 16'h0005;
	localparam logic [15:0] CYC_JUMP_IF_COUNT_ZERO_T = 16'h000f;
	localparam logic [15:0] CYC_LOOP_NT = 16'h0006;
	localparam logic [15:0] CYC_LOOP_T = 16'h0010;
	localparam logic [15:0] CYC_ENTER_L0 = 16'h0013;
	localparam logic [15:0] CYC_ENTER_L1 = 16'h001d;
	localparam logic [15:0] CYC_ENTER_BASE = 16'h001c;
	localparam logic [15:0] CYC_ENTER_STEP = 16'h0014;
	localparam logic [15:0] CYC_LEAVE = 16'h0008;
	localparam logic [15:0] CYC_INT = 16'h002f;
	localparam logic [15:0] CYC_INT3 = 16'h002d;
	localparam logic [15:0] CYC_INTERRUPT_ON_OVERFLOW_T = 16'h0030;
	localparam logic [15:0] CYC_INTERRUPT_ON_OVERFLOW_NT = 16'h0004;
	localparam logic [15:0] CYC_INTERRUPT_RETURN = 16'h001c;
	localparam logic [15:0] CYC_BOUND_OK = 16'h0021;
	localparam logic [15:0] CYC_BOUND_TRAP = 16'h0023;
	localparam logic [15:0] CYC_SHORT_OP = 16'h0002;
	localparam logic [15:0] CYC_WAIT = 16'h0006;
	localparam logic [15:0] CYC_NOP = 16'h0003;
	localparam logic [15:0] CYC_WORD_XFER = 16'h0004;
	// Address computation cost, already inside the figures above
	localparam logic [15:0] CYC_EA = 16'h0004;
endpackage

/* hw/ctd_decoder.sv */
// Control-transfer and processor-control instruction decoder
`timescale 1ns/10ps
`default_nettype none
module ctd_decoder #(
	parameter logic [7:0] OVERFLOW_VECTOR = 8'h04,
	parameter logic [7:0] BOUND_VECTOR = 8'h05
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction byte stream
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	// Architectural state from the execution unit
	input wire logic [15:0] next_ip,
	input wire logic [15:0] count_register,
	input wire logic [15:0] operand_value,
	input wire logic flag_carry,
	input wire logic flag_zero,
	input wire logic flag_sign,
	input wire logic flag_overflow,
	input wire logic flag_parity,
	input wire logic word_operand,
	input wire logic bound_fail,
	input wire logic irq_pending,
	input wire logic test_n,
	// Completion and transfer results
	output logic instr_done,
	output logic illegal_op,
	output logic branch_taken,
	output logic far_transfer,
	output logic [15:0] target_ip,
	output logic [15:0] target_cs,
	// Count register update
	output logic count_write,
	output logic [15:0] count_next,
	// Stack and frame operations
	output logic return_pop,
	output logic [15:0] stack_release,
	output logic frame_enter,
	output logic frame_leave,
	output logic [15:0] frame_size,
	output logic [7:0] nest_level,
	// Interrupts and flags
	output logic int_request,
	output logic int_return,
	output logic [7:0] int_vector,
	output logic carry_load,
	output logic carry_value,
	output logic direction_flag,
	output logic irq_enable,
	// Bus lock and halt
	output logic lock,
	output logic halted
);
	// =========================================================
	// State
	typedef enum logic [5:0] {
		S_OPCODE = 6'b000001,
		S_OPERAND = 6'b000010,
		S_EVAL = 6'b000100,
		S_STALL = 6'b001000,
		S_EXEC = 6'b010000,
		S_HALT = 6'b100000
	} ctd_state_t;

	ctd_state_t state;
	logic [7:0] opcode;
	logic [7:0] opnd [4];
	logic [1:0] idx;
	logic [2:0] need;
	logic [15:0] cnt;
	logic take;
	logic [15:0] cycles;
	logic [2:0] base_need;
	logic [2:0] disp_need;
	logic [1:0] xfers;
	logic cond;
	logic last_byte;
	logic finish;
	logic take_q;
	logic [15:0] tgt_q;

	wire [1:0] md = opnd[0][7:6];
	wire [2:0] rg = opnd[0][5:3];
	wire [7:0] lvl = opnd[2];
	wire [15:0] rel8 = {{8{opnd[0][7]}}, opnd[0]};
	wire is_jcc = opcode[7:4] == ctd_pkg::OP_JCC_HIGH;
	wire is_loop = opcode == ctd_pkg::OP_LOOP ||
		opcode == ctd_pkg::OP_LOOPZ || opcode == ctd_pkg::OP_LOOPNZ;
	wire is_ind = opcode == ctd_pkg::OP_GROUP_FF &&
		(rg == ctd_pkg::REG_JMP_IND || rg == ctd_pkg::REG_JMP_FAR_IND);

	assign byte_ready = state == S_OPCODE || state == S_OPERAND;
	assign halted = state == S_HALT;
	assign finish = state == S_EXEC && cnt == 16'h0001;

	// =========================================================
	// Operand byte counts
	always_comb
	begin
		base_need = 3'h0;
		if (byte_data[7:4] == ctd_pkg::OP_JCC_HIGH)
			base_need = 3'h1;
		unique case (byte_data)
			ctd_pkg::OP_JMP_SHORT, ctd_pkg::OP_JUMP_IF_COUNT_ZERO, ctd_pkg::OP_LOOP,
			ctd_pkg::OP_LOOPZ, ctd_pkg::OP_LOOPNZ, ctd_pkg::OP_INT:
				base_need = 3'h1;
			ctd_pkg::OP_JMP_NEAR, ctd_pkg::OP_RET_NEAR_IMM,
			ctd_pkg::OP_RET_FAR_IMM:
				base_need = 3'h2;
			ctd_pkg::OP_JMP_FAR: base_need = 3'h4;
			ctd_pkg::OP_ENTER: base_need = 3'h3;
			ctd_pkg::OP_GROUP_FF, ctd_pkg::OP_BOUND:
				base_need = 3'h1;
			default: ;
		endcase
	end

	// Displacement bytes trailing a mod-reg-r/m byte
	always_comb
	begin
		disp_need = 3'h0;
		if (byte_data[7:6] == ctd_pkg::MOD_DISP8)
			disp_need = 3'h1;
		else if (byte_data[7:6] == ctd_pkg::MOD_DISP16)
			disp_need = 3'h2;
		else if (byte_data[7:6] == 2'h0 &&
			byte_data[2:0] == ctd_pkg::RM_DIRECT)
			disp_need = 3'h2;
	end

	assign last_byte = state == S_OPERAND && byte_valid &&
		need == 3'h1 &&
		!(idx == 2'h0 && (opcode == ctd_pkg::OP_GROUP_FF ||
		opcode == ctd_pkg::OP_BOUND) && disp_need != 3'h0);

	// =========================================================
	// Branch condition, sampled at evaluation
	always_comb
	begin
		cond = 1'b0;
		if (is_jcc)
		begin
			unique case (opcode[3:1])
				3'h0: cond = flag_overflow;
				3'h1: cond = flag_carry;
				3'h2: cond = flag_zero;
				3'h3: cond = flag_carry | flag_zero;
				3'h4: cond = flag_sign;
				3'h5: cond = flag_parity;
				3'h6: cond = flag_sign ^ flag_overflow;
				3'h7: cond = (flag_sign ^ flag_overflow) | flag_zero;
			endcase
			cond = cond ^ opcode[0];
		end
		else if (opcode == ctd_pkg::OP_JUMP_IF_COUNT_ZERO)
			cond = count_register == 16'h0000;
		else if (is_loop)
			cond = count_register != 16'h0001 &&
				(opcode == ctd_pkg::OP_LOOP ||
				(opcode == ctd_pkg::OP_LOOPZ) == flag_zero);
		else if (opcode == ctd_pkg::OP_INTERRUPT_ON_OVERFLOW)
			cond = flag_overflow;
		else if (opcode == ctd_pkg::OP_BOUND)
			cond = bound_fail;
	end

	// =========================================================
	// Cycle counts
	always_comb
	begin
		take = cond;
		xfers = 2'h0;
		cycles = ctd_pkg::CYC_SHORT_OP;
		if (is_jcc)
			cycles = cond ? ctd_pkg::CYC_JCC_T : ctd_pkg::CYC_JCC_NT;
		else if (is_loop)
			cycles = cond ? ctd_pkg::CYC_LOOP_T : ctd_pkg::CYC_LOOP_NT;
		unique case (opcode)
			ctd_pkg::OP_JMP_SHORT, ctd_pkg::OP_JMP_NEAR,
			ctd_pkg::OP_JMP_FAR:
			begin
				cycles = ctd_pkg::CYC_JMP;
				take = 1'b1;
			end
			ctd_pkg::OP_GROUP_FF:
			begin
				take = is_ind;
				if (rg == ctd_pkg::REG_JMP_FAR_IND)
					cycles = ctd_pkg::CYC_JMP_FAR_IND;
				else if (md == ctd_pkg::MOD_REGISTER)
					cycles = ctd_pkg::CYC_JMP_IND_REG;
				else
				begin
					cycles = ctd_pkg::CYC_JMP_IND_MEM;
					xfers = 2'h1;
				end
			end
			ctd_pkg::OP_RET_NEAR: cycles = ctd_pkg::CYC_RET_NEAR;
			ctd_pkg::OP_RET_NEAR_IMM: cycles = ctd_pkg::CYC_RET_NEAR_IMM;
			ctd_pkg::OP_RET_FAR: cycles = ctd_pkg::CYC_RET_FAR;
			ctd_pkg::OP_RET_FAR_IMM: cycles = ctd_pkg::CYC_RET_FAR_IMM;
			ctd_pkg::OP_JUMP_IF_COUNT_ZERO:
				cycles = cond ? ctd_pkg::CYC_JUMP_IF_COUNT_ZERO_T : ctd_pkg::CYC_JUMP_IF_COUNT_ZERO_NT;
			ctd_pkg::OP_ENTER:
				if (lvl == 8'h00)
					cycles = ctd_pkg::CYC_ENTER_L0;
				else if (lvl == 8'h01)
					cycles = ctd_pkg::CYC_ENTER_L1;
				else
					cycles = 16'(ctd_pkg::CYC_ENTER_BASE +
						ctd_pkg::CYC_ENTER_STEP * ({8'h00, lvl} - 16'h0001));
			ctd_pkg::OP_LEAVE: cycles = ctd_pkg::CYC_LEAVE;
			ctd_pkg::OP_INT: cycles = ctd_pkg::CYC_INT;
			ctd_pkg::OP_INT3: cycles = ctd_pkg::CYC_INT3;
			ctd_pkg::OP_INTERRUPT_ON_OVERFLOW:
				cycles = cond ? ctd_pkg::CYC_INTERRUPT_ON_OVERFLOW_T : ctd_pkg::CYC_INTERRUPT_ON_OVERFLOW_NT;
			ctd_pkg::OP_INTERRUPT_RETURN: cycles = ctd_pkg::CYC_INTERRUPT_RETURN;
			ctd_pkg::OP_BOUND:
			begin
				cycles = cond ? ctd_pkg::CYC_BOUND_TRAP :
					ctd_pkg::CYC_BOUND_OK;
				xfers = 2'h2;
			end
			ctd_pkg::OP_WAIT: cycles = ctd_pkg::CYC_WAIT;
			ctd_pkg::OP_NOP: cycles = ctd_pkg::CYC_NOP;
			default: ;
		endcase
		if (word_operand)
			cycles = 16'(cycles + ctd_pkg::CYC_WORD_XFER * {14'h0, xfers});
	end

	// =========================================================
	// Sequencer
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= S_OPCODE;
			opcode <= 8'h00;
			idx <= 2'h0;
			need <= 3'h0;
			cnt <= 16'h0000;
		end
		else
		begin
			unique case (state)
				S_OPCODE:
					if (byte_valid)
					begin
						opcode <= byte_data;
						idx <= 2'h0;
						need <= base_need;
						state <= base_need == 3'h0 ? S_EVAL : S_OPERAND;
					end
				S_OPERAND:
					if (byte_valid)
					begin
						if (idx != 2'h3)
							idx <= idx + 2'h1;
						if (idx == 2'h0 && is_modrm_q(opcode))
							need <= 3'(need - 3'h1 + disp_need);
						else
							need <= need - 3'h1;
						if (last_byte)
							state <= S_EVAL;
					end
				S_EVAL:
					if (opcode == ctd_pkg::OP_WAIT && test_n)
						state <= S_STALL;
					else
					begin
						cnt <= cycles - 16'h0001;
						state <= S_EXEC;
					end
				S_STALL:
					if (!test_n)
						state <= S_EVAL;
				S_EXEC:
					if (finish)
						state <= opcode == ctd_pkg::OP_HLT ? S_HALT : S_OPCODE;
					else
						cnt <= cnt - 16'h0001;
				S_HALT:
					if (irq_pending)
						state <= S_OPCODE;
			endcase
		end
	end

	function automatic logic is_modrm_q(input logic [7:0] op);
		return op == ctd_pkg::OP_GROUP_FF || op == ctd_pkg::OP_BOUND;
	endfunction

	// Operand capture; later displacement bytes fold into the last slot
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			opnd <= '{default: 8'h00};
		else if (state == S_OPERAND && byte_valid)
			opnd[idx] <= byte_data;
	end

	// =========================================================
	// Decision and target, latched at evaluation
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			take_q <= 1'b0;
			tgt_q <= 16'h0000;
		end
		else if (state == S_EVAL)
		begin
			take_q <= take;
			if (opcode == ctd_pkg::OP_JMP_NEAR)
				tgt_q <= next_ip + {opnd[1], opnd[0]};
			else if (opcode == ctd_pkg::OP_JMP_FAR)
				tgt_q <= {opnd[1], opnd[0]};
			else if (opcode == ctd_pkg::OP_GROUP_FF)
				tgt_q <= operand_value;
			else
				tgt_q <= next_ip + rel8;
		end
	end

	// =========================================================
	// Results after the last execution cycle; strobes pulse for one cycle, values such as target_ip hold
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			instr_done <= 1'b0;
			illegal_op <= 1'b0;
			branch_taken <= 1'b0;
			far_transfer <= 1'b0;
			target_ip <= 16'h0000;
			target_cs <= 16'h0000;
			count_write <= 1'b0;
			count_next <= 16'h0000;
			return_pop <= 1'b0;
			stack_release <= 16'h0000;
			frame_enter <= 1'b0;
			frame_leave <= 1'b0;
			frame_size <= 16'h0000;
			nest_level <= 8'h00;
			int_request <= 1'b0;
			int_return <= 1'b0;
			int_vector <= 8'h00;
			carry_load <= 1'b0;
			carry_value <= 1'b0;
		end
		else
		begin
			instr_done <= finish;
			illegal_op <= finish && !known(opcode) ||
				finish && opcode == ctd_pkg::OP_GROUP_FF && !is_ind;
			branch_taken <= finish && take_q &&
				(is_jcc || is_loop || opcode == ctd_pkg::OP_JUMP_IF_COUNT_ZERO ||
				opcode == ctd_pkg::OP_JMP_SHORT ||
				opcode == ctd_pkg::OP_JMP_NEAR ||
				opcode == ctd_pkg::OP_JMP_FAR || is_ind);
			far_transfer <= finish && (opcode == ctd_pkg::OP_JMP_FAR ||
				opcode == ctd_pkg::OP_RET_FAR ||
				opcode == ctd_pkg::OP_RET_FAR_IMM ||
				(is_ind && rg == ctd_pkg::REG_JMP_FAR_IND));
			if (finish && take_q)
				target_ip <= tgt_q;
			if (finish && opcode == ctd_pkg::OP_JMP_FAR)
				target_cs <= {opnd[3], opnd[2]};
			// count decremented by every loop form
			count_write <= finish && is_loop;
			if (finish && is_loop)
				count_next <= count_register - 16'h0001;
			return_pop <= finish && (opcode[7:4] == 4'hc &&
				opcode[2:1] == 2'h1);
			if (finish)
				stack_release <= opcode[0] ? 16'h0000 : {opnd[1], opnd[0]};
			frame_enter <= finish && opcode == ctd_pkg::OP_ENTER;
			frame_leave <= finish && opcode == ctd_pkg::OP_LEAVE;
			if (finish && opcode == ctd_pkg::OP_ENTER)
			begin
				frame_size <= {opnd[1], opnd[0]};
				nest_level <= lvl;
			end
			int_request <= finish && (opcode == ctd_pkg::OP_INT ||
				opcode == ctd_pkg::OP_INT3 || (take_q &&
				(opcode == ctd_pkg::OP_INTERRUPT_ON_OVERFLOW || opcode == ctd_pkg::OP_BOUND)));
			if (finish)
				int_vector <= opcode == ctd_pkg::OP_INT ? opnd[0] :
					opcode == ctd_pkg::OP_INTERRUPT_ON_OVERFLOW ? OVERFLOW_VECTOR :
					opcode == ctd_pkg::OP_BOUND ? BOUND_VECTOR :
					ctd_pkg::VEC_BREAK;
			int_return <= finish && opcode == ctd_pkg::OP_INTERRUPT_RETURN;
			carry_load <= finish && (opcode == ctd_pkg::OP_CLC ||
				opcode == ctd_pkg::OP_CMC || opcode == ctd_pkg::OP_STC);
			if (finish)
				carry_value <= opcode == ctd_pkg::OP_STC ||
					(opcode == ctd_pkg::OP_CMC && !flag_carry);
		end
	end

	function automatic logic known(input logic [7:0] op);
		return op[7:4] == ctd_pkg::OP_JCC_HIGH || op == ctd_pkg::OP_GROUP_FF ||
			op == ctd_pkg::OP_JMP_SHORT || op == ctd_pkg::OP_JMP_NEAR ||
			op == ctd_pkg::OP_JMP_FAR || (op[7:4] == 4'hc && op[3:1] != 3'h2
			&& op[3:1] != 3'h0) || op == ctd_pkg::OP_ENTER ||
			op == ctd_pkg::OP_LEAVE || op[7:2] == 6'h38 ||
			op == ctd_pkg::OP_BOUND || op == ctd_pkg::OP_CLC ||
			op == ctd_pkg::OP_CMC || op == ctd_pkg::OP_STC ||
			op == ctd_pkg::OP_CLD || op == ctd_pkg::OP_STD ||
			op == ctd_pkg::OP_CLI || op == ctd_pkg::OP_STI ||
			op == ctd_pkg::OP_HLT || op == ctd_pkg::OP_WAIT ||
			op == ctd_pkg::OP_LOCK || op == ctd_pkg::OP_NOP;
	endfunction

	// =========================================================
	// Owned flags and bus lock
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			direction_flag <= 1'b0;
			irq_enable <= 1'b0;
		end
		else if (finish)
		begin
			if (opcode == ctd_pkg::OP_CLD || opcode == ctd_pkg::OP_STD)
				direction_flag <= opcode[0];
			if (opcode == ctd_pkg::OP_CLI || opcode == ctd_pkg::OP_STI)
				irq_enable <= opcode[0];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			lock <= 1'b0;
		// held until the next instruction completes
		else if (finish)
			lock <= opcode == ctd_pkg::OP_LOCK;
	end
endmodule // ctd_decoder
`default_nettype wire

/* bench/ctd_fetch_model.sv */
// Fetch queue model that feeds the decoder byte stream
`timescale 1ns/10ps
`default_nettype none
module ctd_fetch_model (
	// Clock
	input wire logic clk,
	// Byte stream
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data,
	// Pacing
	input wire logic slow
);
	// ========
	// Queue and driver
	logic [7:0] q[$];
	logic took;
	initial
	begin
		byte_valid = 1'b0;
		byte_data = 8'h00;
	end
	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask
	// Idle data toggles so a stale byte never looks held
	always @(posedge clk)
	begin
		took = byte_valid && byte_ready;
		if (took)
			void'(q.pop_front());
		#1;
		byte_valid = q.size() != 0 && !(took && slow);
		byte_data = byte_valid ? q[0] : ~byte_data;
	end
endmodule // ctd_fetch_model
`default_nettype wire

/* bench/ctd_decoder_sva.sv */
// Port-level properties of the control-transfer decoder
`timescale 1ns/10ps
`default_nettype none
module ctd_decoder_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic byte_ready,
	input wire logic instr_done,
	input wire logic illegal_op,
	input wire logic branch_taken,
	input wire logic far_transfer,
	input wire logic count_write,
	input wire logic [15:0] count_next,
	input wire logic [15:0] count_register,
	input wire logic carry_load,
	input wire logic direction_flag,
	input wire logic irq_enable,
	input wire logic lock,
	input wire logic halted,
	input wire logic irq_pending
);
	// ========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_DONE_PULSE: assert property (instr_done |=> !instr_done)
		else $error("done held too long");
	AST_BRANCH_DONE: assert property (branch_taken |-> instr_done)
		else $error("branch without done");
	AST_FAR_DONE: assert property (far_transfer |-> instr_done)
		else $error("far transfer without done");
	AST_ILLEGAL: assert property (illegal_op |-> instr_done && !branch_taken)
		else $error("bad illegal pulse");
	AST_READY_DONE: assert property (instr_done && !halted |-> byte_ready)
		else $error("not ready at done");
	AST_BUSY_BOUND: assert property ($fell(byte_ready) && !halted
		|-> ##[1:400] (instr_done || halted))
		else $error("instruction never finished");
	AST_COUNT: assert property (count_write
		|-> instr_done && count_next == count_register - 16'h0001)
		else $error("bad count update");
	AST_LOCK_MOVE: assert property ($changed(lock) |-> instr_done)
		else $error("lock moved off done");
	AST_FLAG_MOVE: assert property ($changed(direction_flag)
		|| $changed(irq_enable) |-> instr_done)
		else $error("flag moved off done");
	AST_CARRY_DONE: assert property (carry_load |-> instr_done)
		else $error("carry load off done");
	AST_WAKE: assert property (halted && irq_pending |=> !halted)
		else $error("halt not left");
endmodule // ctd_decoder_sva
bind ctd_decoder ctd_decoder_sva u_sva (.clk, .rst, .byte_ready, .instr_done,
	.illegal_op, .branch_taken, .far_transfer, .count_write, .count_next,
	.count_register, .carry_load, .direction_flag, .irq_enable, .lock,
	.halted, .irq_pending);
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the control-transfer decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ========
	// Signals
	logic clk = 1'b0, rst = 1'b1, slow = 1'b0, got = 1'b0;
	logic [15:0] next_ip = 16'h1000, count_register = 16'h0000;
	logic [15:0] operand_value = 16'h2468;
	logic flag_carry = 1'b0, flag_zero = 1'b0, flag_sign = 1'b0;
	logic flag_overflow = 1'b0, flag_parity = 1'b0, word_operand = 1'b0;
	logic bound_fail = 1'b0, irq_pending = 1'b0, test_n = 1'b0;
	logic byte_valid, byte_ready, instr_done, illegal_op, branch_taken;
	logic far_transfer, count_write, return_pop, frame_enter, frame_leave;
	logic int_request, int_return, carry_load, carry_value, direction_flag;
	logic irq_enable, lock, halted;
	logic [7:0] byte_data, int_vector, nest_level;
	logic [15:0] target_ip, target_cs, count_next, stack_release, frame_size;
	logic [9:0] pl;
	logic [7:0] fo[7] = '{8'hf9, 8'hf8, 8'hf5, 8'hfd, 8'hfc, 8'hfb, 8'hfa};
	logic [2:0] fv[7] = '{3'h1, 3'h0, 3'h1, 3'h2, 3'h0, 3'h4, 3'h0};
	int cyc = 0, last_take = 0, done_at = 0, err_count = 0, n_checks = 0;
	ctd_decoder uut (.clk, .rst, .byte_valid, .byte_data, .byte_ready,
		.next_ip, .count_register, .operand_value, .flag_carry, .flag_zero,
		.flag_sign, .flag_overflow, .flag_parity, .word_operand, .bound_fail,
		.irq_pending, .test_n, .instr_done, .illegal_op, .branch_taken,
		.far_transfer, .target_ip, .target_cs, .count_write, .count_next,
		.return_pop, .stack_release, .frame_enter, .frame_leave, .frame_size,
		.nest_level, .int_request, .int_return, .int_vector, .carry_load,
		.carry_value, .direction_flag, .irq_enable, .lock, .halted);
	ctd_fetch_model fq (.clk, .byte_ready, .byte_valid, .byte_data, .slow);
	initial
	begin
		forever #5 clk = ~clk;
	end
	// Pulses are caught at the edge that ends them
	always @(posedge clk)
	begin
		cyc++;
		if (byte_valid && byte_ready)
			last_take = cyc;
		if (instr_done === 1'b1)
		begin
			got = 1'b1;
			done_at = cyc;
			pl = {illegal_op, branch_taken, far_transfer, return_pop,
				frame_enter, frame_leave, int_request, int_return,
				count_write, carry_load};
		end
	end
	// ========
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Done is seen N+1 edges after the edge taking the last byte
	task automatic go(input int n, input logic [9:0] p);
		int t;
		t = 0;
		do
		begin
			@(posedge clk);
			#1;
			t++;
		end
		while (!got && t < 500);
		chk("done", got, 1'b1);
		if (n > 0)
			chk("cycles", done_at - last_take, n + 1);
		chk("pulses", pl, p);
		got = 1'b0;
	endtask
	task automatic op(input logic [7:0] a, input int nb,
		input logic [31:0] v, input int n, input logic [9:0] p);
		fq.push(a);
		for (int i = 0; i < nb; i++)
			fq.push(v[8*i +: 8]);
		go(n, p);
	endtask
	initial
	begin
		#200000;
		err_count++;
		stop_test;
	end
	// ========
	// Scenarios
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		t_jumps;
		t_returns;
		t_cond;
		t_loops;
		t_frames;
		t_ints;
		t_flags;
		t_lock_reset;
		t_wait_halt;
		stop_test;
	end
	task automatic t_jumps;
		op(8'heb, 1, 32'hf0, 14, 10'h100);
		chk("short", target_ip, 16'h0ff0);
		slow = 1'b1;
		op(8'hea, 4, 32'h5678_1234, 14, 10'h180);
		chk("far", {target_cs, target_ip}, 32'h5678_1234);
		op(8'he9, 2, 32'h0010, 14, 10'h100);
		slow = 1'b0;
		op(8'hff, 1, 32'he0, 11, 10'h100);
		chk("indirect", target_ip, 16'h2468);
		op(8'hff, 1, 32'h27, 21, 10'h100);
		word_operand = 1'b1;
		op(8'hff, 1, 32'h27, 25, 10'h100);
		word_operand = 1'b0;
		op(8'hff, 1, 32'hc0, 0, 10'h200);
	endtask
	task automatic t_returns;
		op(8'hc3, 0, 0, 20, 10'h040);
		op(8'hcb, 0, 0, 30, 10'h0c0);
		op(8'hc2, 2, 32'h0004, 22, 10'h040);
		op(8'hca, 2, 32'h0100, 33, 10'h0c0);
		chk("release", stack_release, 16'h0100);
	endtask
	task automatic t_cond;
		for (int c = 0; c < 16; c++)
			op({4'h7, c[3:0]}, 1, 5, c[0] ? 13 : 4, {1'b0, c[0], 8'h00});
		chk("cond", target_ip, 16'h1005);
		flag_sign = 1'b1;
		op(8'h7c, 1, 5, 13, 10'h100);
		op(8'h78, 1, 5, 13, 10'h100);
		flag_parity = 1'b1;
		op(8'h7b, 1, 5, 4, 10'h000);
		flag_sign = 1'b0;
		flag_parity = 1'b0;
		flag_zero = 1'b1;
		op(8'h74, 1, 32'h80, 13, 10'h100);
		chk("backward", target_ip, 16'h0f80);
	endtask
	task automatic t_loops;
		flag_zero = 1'b1;
		count_register = 16'h0000;
		op(8'he3, 1, 32'h02, 15, 10'h100);
		count_register = 16'h0003;
		op(8'he3, 1, 32'h02, 5, 10'h000);
		op(8'he2, 1, 32'h02, 16, 10'h102);
		chk("count", count_next, 16'h0002);
		op(8'he1, 1, 32'h02, 16, 10'h102);
		op(8'he0, 1, 32'h02, 6, 10'h002);
		flag_zero = 1'b0;
		op(8'he1, 1, 32'h02, 6, 10'h002);
		op(8'he0, 1, 32'h02, 16, 10'h102);
		count_register = 16'h0001;
		op(8'he2, 1, 32'h02, 6, 10'h002);
	endtask
	task automatic t_frames;
		op(8'hc8, 3, 32'h00_0010, 19, 10'h020);
		chk("frame", frame_size, 16'h0010);
		op(8'hc8, 3, 32'h01_0010, 29, 10'h020);
		op(8'hc8, 3, 32'h03_0010, 68, 10'h020);
		chk("level", nest_level, 8'h03);
		op(8'hc9, 0, 0, 8, 10'h010);
	endtask
	task automatic t_ints;
		op(8'hcd, 1, 32'h21, 47, 10'h008);
		chk("type", int_vector, 8'h21);
		op(8'hcc, 0, 0, 45, 10'h008);
		chk("break", int_vector, 8'h03);
		op(8'hce, 0, 0, 4, 10'h000);
		flag_overflow = 1'b1;
		op(8'hce, 0, 0, 48, 10'h008);
		op(8'hcf, 0, 0, 28, 10'h004);
		op(8'h62, 1, 32'h07, 33, 10'h000);
		bound_fail = 1'b1;
		op(8'h62, 1, 32'h07, 35, 10'h008);
	endtask
	task automatic t_flags;
		for (int i = 0; i < 7; i++)
		begin
			op(fo[i], 0, 0, 2, {9'h000, i < 3});
			chk("fl", {irq_enable, direction_flag, carry_value}, fv[i]);
		end
		flag_carry = 1'b1;
		op(8'hf5, 0, 0, 2, 10'h001);
		chk("cmc", carry_value, 1'b0);
		flag_carry = 1'b0;
	endtask
	task automatic t_lock_reset;
		op(8'hf0, 0, 0, 2, 10'h000);
		chk("lock", lock, 1'b1);
		op(8'hf8, 0, 0, 2, 10'h001);
		chk("unlock", lock, 1'b0);
		op(8'hfd, 0, 0, 2, 10'h000);
		op(8'hf0, 0, 0, 2, 10'h000);
		rst = 1'b1;
		@(posedge clk);
		#1;
		chk("reset", {lock, direction_flag, byte_ready}, 3'h1);
		rst = 1'b0;
		op(8'h90, 0, 0, 3, 10'h000);
		chk("nop", target_ip, 16'h0000);
	endtask
	task automatic t_wait_halt;
		test_n = 1'b1;
		fq.push(8'h9b);
		repeat (10) @(posedge clk);
		#1;
		chk("stall", got, 1'b0);
		test_n = 1'b0;
		go(0, 10'h000);
		op(8'hf4, 0, 0, 2, 10'h000);
		repeat (3) @(posedge clk);
		#1;
		chk("halt", halted, 1'b1);
		irq_pending = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("wake", halted, 1'b0);
	endtask
endmodule // testbench
`default_nettype wire
